/* hdl/freq_cond_pkg.sv */
// package: constants, encodings and parameter groups of the frequency
// command conditioner.
// assumes frequencies in 0.01 Hz steps and process values in 0.01 % steps.
package freq_cond_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 32'h64;              // 100 MHz system clock
  localparam int TICK_US = 32'h3e8;             // control period, 1000 us
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int DWELL_UNIT_US = 32'h186a0;     // dwell time step, 0.1 s
  localparam int TICKS_PER_DWELL = DWELL_UNIT_US / TICK_US;
  localparam int ITIME_UNIT_US = 32'h186a0;     // integral time step, 0.1 s
  localparam int TICKS_PER_ITIME = ITIME_UNIT_US / TICK_US;
  localparam int DTIME_UNIT_US = 32'h2710;      // derivative step, 0.01 s
  localparam int D_FACTOR = DTIME_UNIT_US / TICK_US;

  // ****************************************
  // scaling
  // ****************************************
  localparam int PCT_FULL = 32'h2710;           // 100.00 %
  localparam int TENTH_PCT = 32'ha;             // 0.1 % in 0.01 % steps
  localparam int GAIN_DIV = 32'ha;              // gain step 0.1
  localparam int SCALE_DIV = 32'h64;            // scale step 0.01

  // ****************************************
  // encodings
  // ****************************************
  typedef enum logic [1:0] {
    PID_OFF = 2'h0, PID_ON = 2'h1, PID_INVERT = 2'h2
  } pid_mode_t;
  typedef enum logic [7:0] {
    FB_CURRENT = 8'h00, FB_VOLTAGE = 8'h01, FB_SERIAL = 8'h02,
    FB_PULSE = 8'h03, FB_ARITH = 8'h10
  } fb_source_t;
  typedef enum logic [1:0] {
    FF_NONE = 2'h0, FF_VOLTAGE = 2'h1, FF_CURRENT = 2'h2, FF_BIPOLAR = 2'h3
  } ff_source_t;
  localparam logic [1:0] RUN_SRC_TERMINAL = 2'h1;
  localparam logic [1:0] DIR_REVERSE = 2'h1;
  localparam logic [1:0] DEV_INVERT = 2'h1;
  localparam logic [1:0] MOTOR_SET_2 = 2'h1;
  localparam logic [1:0] MOTOR_SET_3 = 2'h2;

  // ****************************************
  // parameter groups
  // ****************************************
  typedef struct packed {
    logic [15:0] upper_limit_set1;
    logic [15:0] upper_limit_set2;
    logic [15:0] lower_limit_set1;
    logic [15:0] lower_limit_set2;
    logic [15:0] max_frequency_set1;
    logic [1:0] active_set;
  } limit_cfg_t;
  typedef struct packed {
    logic [15:0] jump_center_1;
    logic [15:0] jump_halfwidth_1;
    logic [15:0] jump_center_2;
    logic [15:0] jump_halfwidth_2;
    logic [15:0] jump_center_3;
    logic [15:0] jump_halfwidth_3;
  } jump_cfg_t;
  typedef struct packed {
    logic [15:0] accel_dwell_frequency;
    logic [9:0] accel_dwell_time;
  } dwell_cfg_t;
  typedef struct packed {
    pid_mode_t pid_enable_field;
    logic [5:0] pid_p_gain;
    logic [15:0] pid_i_time;
    logic [15:0] pid_d_time;
    logic [13:0] feedback_scale;
    fb_source_t feedback_source;
    logic [1:0] deviation_invert;
    logic [9:0] variation_range;
    ff_source_t feedforward_source;
    logic [9:0] deviation_threshold;
    logic [9:0] feedback_compare_off_level;
    logic [9:0] feedback_compare_on_level;
  } pid_cfg_t;
  typedef struct packed {
    logic [15:0] current_input;
    logic [15:0] voltage_input;
    logic signed [15:0] bipolar_voltage_input;
    logic [15:0] serial_feedback;
    logic [15:0] pulse_feedback;
    logic [15:0] arith_result;
  } analog_in_t;

endpackage

/* hdl/frequency_command_conditioner.sv */
// frequency command conditioner: pid process loop, frequency limits,
// jump bands, ramp with acceleration dwell.
// assumes parameter groups and analog values come from clk_sys logic;
// run and pid-suspend terminals are asynchronous pins.
//
// What this block does
// [RQ1] clamp accepted command between the upper and lower limit
// [RQ2] both limits zero means no limiting
// [RQ3] third motor set active bypasses limiting
// [RQ4] sets 1 and 2 each hold their own upper and lower limit values
// [RQ5] bipolar source at zero volts runs at the lower limit
// [RQ6] zero-volt direction follows run terminals or operator direction
// [RQ7] up to three jump bands, no steady output inside a band
// [RQ8] centers 0 to 400 Hz, widths 0 to 10 Hz half bandwidth
// [RQ9] a zero center disables its band
// [RQ10] ramps sweep straight through bands at the ramp rate
// [RQ11] on start hold acceleration at dwell frequency for dwell time
// [RQ12] dwell works whatever the acceleration curve shape
// [RQ13] pid mode 00 off, 01 on, 02 on with negative inverted
// [RQ14] suspend terminal on gives the plain non-pid command
// [RQ15] gain 0.2-5.0, integral 0-3600 s, derivative 0-100 s
// [RQ16] feedback monitor is feedback times a 0.01-99.99 scale
// [RQ17] feedback source 00 current, 01 voltage, 02 serial, 03 pulse, 10 calc
// [RQ18] inversion 01 negates the deviation, 00 leaves it
// [RQ19] variation range bounds pid output around the target, in mode 01 only
// [RQ20] feed-forward 00 none, 01 voltage, 02 current, 03 bipolar
// [RQ21] deviation and feedback compare thresholds drive status outputs
// [RQ22] pid output sums proportional, integral and derivative terms
// [RQ23] deviation output on while pid runs and deviation exceeds its threshold
// [RQ24] normal mode clamps negatives to zero, inverted mode flips them
// [RQ25] variation range zero disables the variation limit
// [RQ26] steady command inside a band sits at the nearest edge
`timescale 1ns/1ps
module frequency_command_conditioner #(
  parameter int TICK_CYCLES = freq_cond_pkg::TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire freq_cond_pkg::limit_cfg_t limit_cfg,
  input wire freq_cond_pkg::jump_cfg_t jump_cfg,
  input wire freq_cond_pkg::dwell_cfg_t dwell_cfg,
  input wire freq_cond_pkg::pid_cfg_t pid_cfg,
  input wire freq_cond_pkg::analog_in_t analog,
  input wire logic [15:0] output_frequency_setting,
  input wire logic freq_from_bipolar,
  input wire logic [15:0] pid_target,
  input wire logic [15:0] accel_step,
  input wire logic [1:0] run_command_source,
  input wire logic [1:0] operator_direction,
  input wire logic operator_run,
  input wire logic forward_run_input,
  input wire logic reverse_run_input,
  input wire logic pid_suspend_input,
  output logic [15:0] output_frequency,
  output logic reverse_direction,
  output logic dwell_active,
  output logic pid_active,
  output logic deviation_exceeded_output,
  output logic feedback_compare_output,
  output logic [19:0] feedback_monitor
);

  // ****************************************
  // pin synchronisers and control tick
  // ****************************************
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [31:0] tick_cnt;
  logic tick;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
    end else begin
      pin_meta <= {pid_suspend_input, reverse_run_input, forward_run_input};
      pin_sync <= pin_meta;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || tick) begin
      tick_cnt <= 32'h0;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end
  assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

  logic fw_s, rv_s, susp_s, run;
  assign fw_s = pin_sync[0];
  assign rv_s = pin_sync[1];
  assign susp_s = pin_sync[2];
  assign run = (run_command_source == freq_cond_pkg::RUN_SRC_TERMINAL) ?
               (fw_s | rv_s) : operator_run;

  // ****************************************
  // pid loop
  // ****************************************
  logic signed [31:0] fb, ff, tgt, err, err_prev, i_term, d_term;
  logic signed [47:0] sum, r;
  logic signed [39:0] i_acc;
  logic [31:0] pid_pct;
  logic pid_on_c;

  always_comb begin
    unique case (pid_cfg.feedback_source) // RQ17
      freq_cond_pkg::FB_CURRENT: fb = 32'(analog.current_input);
      freq_cond_pkg::FB_VOLTAGE: fb = 32'(analog.voltage_input);
      freq_cond_pkg::FB_SERIAL: fb = 32'(analog.serial_feedback);
      freq_cond_pkg::FB_PULSE: fb = 32'(analog.pulse_feedback);
      freq_cond_pkg::FB_ARITH: fb = 32'(analog.arith_result);
      default: fb = 32'h0;
    endcase
    unique case (pid_cfg.feedforward_source) // RQ20
      freq_cond_pkg::FF_NONE: ff = 32'h0;
      freq_cond_pkg::FF_VOLTAGE: ff = 32'(analog.voltage_input);
      freq_cond_pkg::FF_CURRENT: ff = 32'(analog.current_input);
      freq_cond_pkg::FF_BIPOLAR: ff = 32'(analog.bipolar_voltage_input);
    endcase
    tgt = 32'(pid_target);
    err = tgt - fb;
    if (pid_cfg.deviation_invert == freq_cond_pkg::DEV_INVERT) begin
      err = -err; // RQ18
    end
  end

  // integral time zero drops the integral term rather than dividing by it
  always_comb begin
    i_term = 32'h0;
    if (pid_cfg.pid_i_time != 16'h0) begin
      // signed divisor, else a negative accumulator divides as unsigned
      i_term = 32'(i_acc / $signed(40'(pid_cfg.pid_i_time *
               freq_cond_pkg::TICKS_PER_ITIME))); // RQ15
    end
    d_term = 32'((err - err_prev) * 32'(pid_cfg.pid_d_time) *
             32'(freq_cond_pkg::D_FACTOR));
    sum = 48'(err) + 48'(i_term) + 48'(d_term); // RQ22
    r = 48'(sum * $signed(48'(pid_cfg.pid_p_gain)) /
        48'(freq_cond_pkg::GAIN_DIV)) + 48'(ff);
    pid_pct = 32'h0;
    if (pid_cfg.pid_enable_field == freq_cond_pkg::PID_INVERT) begin
      pid_pct = (r < 0) ? 32'(-r) : 32'(r); // RQ24
    end else if (r > 0) begin
      pid_pct = 32'(r);
      if (pid_cfg.variation_range != 10'h0) begin // RQ25
        if (r > 48'(tgt + $signed(32'(pid_cfg.variation_range)) *
                    freq_cond_pkg::TENTH_PCT)) begin
          pid_pct = 32'(tgt + $signed(32'(pid_cfg.variation_range)) *
                    freq_cond_pkg::TENTH_PCT); // RQ19
        end else if (r < 48'(tgt - $signed(32'(pid_cfg.variation_range)) *
                         freq_cond_pkg::TENTH_PCT)) begin
          pid_pct = 32'(tgt - $signed(32'(pid_cfg.variation_range)) *
                    freq_cond_pkg::TENTH_PCT);
        end
      end
    end
    if ($signed(pid_pct) < 0) begin
      pid_pct = 32'h0;
    end else if (pid_pct > 32'(freq_cond_pkg::PCT_FULL)) begin
      pid_pct = 32'(freq_cond_pkg::PCT_FULL);
    end
  end

  assign pid_on_c = (pid_cfg.pid_enable_field != freq_cond_pkg::PID_OFF) &&
                    !susp_s; // RQ13 RQ14

  // accumulator restarts whenever the loop is off, avoiding a kick on resume
  always_ff @(posedge clk_sys) begin
    if (sys_rst || !pid_on_c) begin
      i_acc <= 40'h0;
      err_prev <= 32'h0;
    end else if (tick) begin
      i_acc <= i_acc + 40'(err); // RQ22
      err_prev <= err;
    end
  end

  // ****************************************
  // limits and jump bands
  // ****************************************
  logic [15:0] cmd_in, cmd_lim, cmd_jump, up, lo;
  logic lim_on;
  logic [15:0] centers [3];
  logic [15:0] widths [3];

  assign centers[0] = jump_cfg.jump_center_1;
  assign centers[1] = jump_cfg.jump_center_2;
  assign centers[2] = jump_cfg.jump_center_3;
  assign widths[0] = jump_cfg.jump_halfwidth_1;
  assign widths[1] = jump_cfg.jump_halfwidth_2;
  assign widths[2] = jump_cfg.jump_halfwidth_3;

  always_comb begin
    cmd_in = output_frequency_setting;
    if (pid_on_c) begin
      cmd_in = 16'(pid_pct * 32'(limit_cfg.max_frequency_set1) /
                    32'(freq_cond_pkg::PCT_FULL));
    end
    up = (limit_cfg.active_set == freq_cond_pkg::MOTOR_SET_2) ?
         limit_cfg.upper_limit_set2 : limit_cfg.upper_limit_set1; // RQ4
    lo = (limit_cfg.active_set == freq_cond_pkg::MOTOR_SET_2) ?
         limit_cfg.lower_limit_set2 : limit_cfg.lower_limit_set1;
    lim_on = (limit_cfg.active_set != freq_cond_pkg::MOTOR_SET_3) && // RQ3
             !(up == 16'h0 && lo == 16'h0); // RQ2
    cmd_lim = cmd_in;
    if (lim_on && up != 16'h0 && cmd_lim > up) begin
      cmd_lim = up; // RQ1
    end
    if (lim_on && lo != 16'h0 && cmd_lim < lo) begin
      cmd_lim = lo; // RQ1 RQ5
    end
    cmd_jump = cmd_lim;
    for (int b = 0; b < 3; b++) begin // RQ7 RQ8
      if (centers[b] != 16'h0 && // RQ9
          17'(cmd_jump) + 17'(widths[b]) > 17'(centers[b]) &&
          17'(cmd_jump) < 17'(centers[b]) + 17'(widths[b])) begin
        if (cmd_jump < centers[b]) begin
          cmd_jump = (centers[b] > widths[b]) ?
                     centers[b] - widths[b] : 16'h0; // RQ26
        end else begin
          cmd_jump = 16'(17'(centers[b]) + 17'(widths[b])); // RQ26
        end
      end
    end
  end

  // ****************************************
  // ramp with acceleration dwell
  // ****************************************
  typedef enum logic [1:0] {DW_IDLE, DW_WAIT, DW_HOLD, DW_DONE} dwell_t;
  dwell_t dw_state;
  logic [15:0] steady, goal;
  logic [19:0] dw_cnt;
  logic run_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      steady <= 16'h0;
    end else if (tick) begin
      steady <= run ? cmd_jump : 16'h0;
    end
  end

  // dwell ignores the curve shape: it caps the ramp goal, then pauses the ramp
  always_comb begin
    goal = steady;
    if (dw_state == DW_WAIT && steady > dwell_cfg.accel_dwell_frequency) begin
      goal = dwell_cfg.accel_dwell_frequency; // RQ11 RQ12
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dw_state <= DW_IDLE;
      dw_cnt <= 20'h0;
      run_q <= 1'b0;
    end else if (tick) begin
      run_q <= run;
      unique case (dw_state)
        DW_IDLE: begin
          if (run && !run_q && output_frequency == 16'h0) begin
            dw_state <= (dwell_cfg.accel_dwell_frequency != 16'h0 &&
                         dwell_cfg.accel_dwell_time != 10'h0) ?
                        DW_WAIT : DW_DONE;
          end
        end
        DW_WAIT: begin
          if (!run) begin
            dw_state <= DW_IDLE;
          end else if (output_frequency >=
                       dwell_cfg.accel_dwell_frequency) begin
            dw_state <= DW_HOLD; // RQ11
            dw_cnt <= 20'(dwell_cfg.accel_dwell_time *
                          freq_cond_pkg::TICKS_PER_DWELL);
          end
        end
        DW_HOLD: begin
          if (!run || steady < output_frequency || dw_cnt <= 20'h1) begin
            dw_state <= run ? DW_DONE : DW_IDLE;
          end
          dw_cnt <= dw_cnt - 20'h1;
        end
        DW_DONE: begin
          if (!run && output_frequency == 16'h0) begin
            dw_state <= DW_IDLE;
          end
        end
      endcase
    end
  end

  // ramp moves at most one step per tick, so bands are crossed, not skipped
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      output_frequency <= 16'h0;
    end else if (tick && !(dw_state == DW_HOLD && run &&
                           steady >= output_frequency)) begin
      if (output_frequency < goal) begin // RQ10
        output_frequency <= (17'(goal) - 17'(output_frequency) >
                             17'(accel_step)) ?
                            output_frequency + accel_step : goal;
      end else if (output_frequency > goal) begin
        output_frequency <= (17'(output_frequency) - 17'(goal) >
                             17'(accel_step)) ?
                            output_frequency - accel_step : goal;
      end
    end
  end

  // ****************************************
  // direction and status outputs
  // ****************************************
  logic signed [31:0] abs_err;
  assign abs_err = (err < 0) ? -err : err;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reverse_direction <= 1'b0;
      dwell_active <= 1'b0;
      pid_active <= 1'b0;
      deviation_exceeded_output <= 1'b0;
      feedback_compare_output <= 1'b0;
      feedback_monitor <= 20'h0;
    end else if (tick) begin
      if (run && freq_from_bipolar &&
          analog.bipolar_voltage_input != 16'sh0) begin
        reverse_direction <= analog.bipolar_voltage_input < 0;
      end else if (run) begin // RQ6
        reverse_direction <= (run_command_source ==
                              freq_cond_pkg::RUN_SRC_TERMINAL) ?
                             (rv_s && !fw_s) :
                             (operator_direction == freq_cond_pkg::DIR_REVERSE);
      end
      dwell_active <= (dw_state == DW_HOLD);
      pid_active <= pid_on_c;
      deviation_exceeded_output <= pid_on_c && abs_err >
        32'(pid_cfg.deviation_threshold) * freq_cond_pkg::TENTH_PCT; // RQ23
      if (fb >= 32'(pid_cfg.feedback_compare_on_level) *
                freq_cond_pkg::TENTH_PCT) begin
        feedback_compare_output <= 1'b1; // RQ21
      end else if (fb <= 32'(pid_cfg.feedback_compare_off_level) *
                         freq_cond_pkg::TENTH_PCT) begin
        feedback_compare_output <= 1'b0;
      end
      feedback_monitor <= 20'(fb * 32'(pid_cfg.feedback_scale) /
                              freq_cond_pkg::SCALE_DIV); // RQ16
    end
  end

  // ****************************************
  // checks
  // ****************************************
  upper_clamp_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ1
    (lim_on && up != 16'h0) |-> cmd_lim <= up)
    else $error("command above upper limit");
  no_limit_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ3
    !lim_on |-> cmd_lim == cmd_in)
    else $error("limit applied while bypassed");
  jump_off_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ9
    (centers[0] == 16'h0 && centers[1] == 16'h0 && centers[2] == 16'h0)
    |-> cmd_jump == cmd_lim)
    else $error("disabled band moved the command");
  ramp_step_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ10
    tick |=> 17'(output_frequency) <=
             17'($past(output_frequency)) + 17'($past(accel_step)))
    else $error("ramp skipped ahead");
  dwell_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ11
    (dw_state == DW_HOLD && run && steady >= output_frequency) ##1
    (dw_state == DW_HOLD) |-> $stable(output_frequency))
    else $error("output moved during dwell");
  neg_zero_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ24
    (pid_cfg.pid_enable_field == freq_cond_pkg::PID_ON && r < 0)
    |-> pid_pct == 32'h0)
    else $error("negative pid result not zeroed");
  var_limit_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ19
    (pid_cfg.pid_enable_field == freq_cond_pkg::PID_ON &&
     pid_cfg.variation_range != 10'h0 && tgt >= 0)
    |-> $signed(pid_pct) <= tgt +
        $signed(32'(pid_cfg.variation_range)) * freq_cond_pkg::TENTH_PCT)
    else $error("pid output beyond variation range");
  dev_flag_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ23
    (tick && pid_on_c && abs_err >
     32'(pid_cfg.deviation_threshold) * freq_cond_pkg::TENTH_PCT)
    |=> deviation_exceeded_output)
    else $error("deviation output missing");
  suspend_a: assert property (@(posedge clk_sys) disable iff (sys_rst) // RQ14
    susp_s |-> cmd_in == output_frequency_setting)
    else $error("pid still steering while suspended");

endmodule

/* verification/output_frequency_generator.sv */
// partner model: output frequency generator, turns the commanded
// frequency and direction into a signed motor speed.
// assumes the conditioner's outputs on clk_sys.
`timescale 1ns/1ps
module output_frequency_generator (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [15:0] output_frequency,
  input wire logic reverse_direction,
  output logic signed [16:0] motor_speed
);
  // ****************************************
  // speed stage
  // ****************************************
  // one clock behind the command, like a real modulator stage
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      motor_speed <= 17'sh0;
    end else if (reverse_direction) begin
      motor_speed <= -$signed({1'b0, output_frequency});
    end else begin
      motor_speed <= $signed({1'b0, output_frequency});
    end
  end
endmodule

/* verification/testbench.sv */
// testbench: self-checking scenarios for the frequency command conditioner.
// assumes a short control tick so that ramps and dwell fit a short run.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); \
  miscompares++; end end
module testbench;
  // ****************************************
  // signals and instances
  // ****************************************
  localparam int T = 4;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  freq_cond_pkg::limit_cfg_t lim = '0;
  freq_cond_pkg::jump_cfg_t jmp = '0;
  freq_cond_pkg::dwell_cfg_t dw = '0;
  freq_cond_pkg::pid_cfg_t pid = '0;
  freq_cond_pkg::analog_in_t ana = '0;
  logic [15:0] cmd = 16'h0;
  logic bip = 1'b0;
  logic [15:0] tgt = 16'h0;
  logic [15:0] step = 16'hffff;
  logic [1:0] src = 2'h0;
  logic [1:0] odir = 2'h0;
  logic orun = 1'b1;
  logic fw = 1'b0;
  logic rv = 1'b0;
  logic sus = 1'b0;
  logic [15:0] out_f;
  logic rev, dwell, pid_act, dev_out, cmp_out;
  logic [19:0] mon;
  logic signed [16:0] speed;
  int miscompares = 0;
  int n_tests = 0;
  frequency_command_conditioner #(.TICK_CYCLES(T))
    i_frequency_command_conditioner (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .limit_cfg(lim), .jump_cfg(jmp),
    .dwell_cfg(dw), .pid_cfg(pid), .analog(ana),
    .output_frequency_setting(cmd), .freq_from_bipolar(bip),
    .pid_target(tgt), .accel_step(step), .run_command_source(src),
    .operator_direction(odir), .operator_run(orun),
    .forward_run_input(fw), .reverse_run_input(rv),
    .pid_suspend_input(sus), .output_frequency(out_f),
    .reverse_direction(rev), .dwell_active(dwell), .pid_active(pid_act),
    .deviation_exceeded_output(dev_out),
    .feedback_compare_output(cmp_out), .feedback_monitor(mon));
  output_frequency_generator i_output_frequency_generator (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .output_frequency(out_f),
    .reverse_direction(rev), .motor_speed(speed));
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // a full step per tick, so six ticks reach the steady target unless a dwell holds the ramp
  task settle;
    repeat (6 * T) @(negedge clk_sys);
  endtask
  task conclude;
    $display("tests=%0d mismatches=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task t_limits;
    lim.upper_limit_set1 = 16'h1388;
    lim.lower_limit_set1 = 16'h03e8;
    cmd = 16'h1f40;
    settle;
    `CHK(out_f, 16'h1388);
    cmd = 16'h01f4;
    settle;
    `CHK(out_f, 16'h03e8);
    lim.upper_limit_set2 = 16'h0fa0;
    lim.active_set = freq_cond_pkg::MOTOR_SET_2;
    cmd = 16'h1f40;
    settle;
    `CHK(out_f, 16'h0fa0);
    lim.active_set = freq_cond_pkg::MOTOR_SET_3;
    settle;
    `CHK(out_f, 16'h1f40);
    lim.active_set = 2'h0;
    lim.upper_limit_set1 = 16'h0;
    lim.lower_limit_set1 = 16'h0;
    settle;
    `CHK(out_f, 16'h1f40);
    $display("limits test done");
  endtask
  task t_jump;
    jmp.jump_center_1 = 16'h0bb8;
    jmp.jump_halfwidth_1 = 16'h00c8;
    jmp.jump_halfwidth_2 = 16'h01f4;
    jmp.jump_center_3 = 16'h1770;
    jmp.jump_halfwidth_3 = 16'h0064;
    cmd = 16'h0b54;
    settle;
    `CHK(out_f, 16'h0af0);
    cmd = 16'h0c1c;
    settle;
    `CHK(out_f, 16'h0c80);
    cmd = 16'h0064;
    settle;
    `CHK(out_f, 16'h0064);
    cmd = 16'h173e;
    settle;
    `CHK(out_f, 16'h170c);
    jmp = '0;
    $display("jump test done");
  endtask
  task t_pid;
    pid.pid_enable_field = freq_cond_pkg::PID_ON;
    pid.pid_p_gain = 6'h0a;
    pid.feedback_source = freq_cond_pkg::FB_VOLTAGE;
    pid.deviation_threshold = 10'h00a;
    ana.voltage_input = 16'h1388;
    cmd = 16'h0bb8;
    settle;
    `CHK(out_f, 16'h0000);
    `CHK(pid_act, 1'b1);
    pid.deviation_invert = freq_cond_pkg::DEV_INVERT;
    settle;
    `CHK(out_f, 16'h1388);
    // integral builds on top of the proportional part
    pid.pid_i_time = 16'h0001;
    settle;
    settle;
    `CHK(out_f > 16'h1388, 1'b1);
    pid.pid_i_time = 16'h0;
    pid.variation_range = 10'h00a;
    settle;
    `CHK(out_f, 16'h0064);
    pid.deviation_invert = 2'h0;
    pid.pid_enable_field = freq_cond_pkg::PID_INVERT;
    settle;
    `CHK(out_f, 16'h1388);
    `CHK(dev_out, 1'b1);
    pid.feedforward_source = freq_cond_pkg::FF_CURRENT;
    ana.current_input = 16'h03e8;
    settle;
    `CHK(out_f, 16'h0fa0);
    pid.feedforward_source = freq_cond_pkg::FF_NONE;
    ana.current_input = 16'h0;
    sus = 1'b1;
    settle;
    `CHK(out_f, 16'h0bb8);
    `CHK(pid_act, 1'b0);
    `CHK(dev_out, 1'b0);
    sus = 1'b0;
    pid.pid_enable_field = freq_cond_pkg::PID_OFF;
    settle;
    `CHK(pid_act, 1'b0);
    $display("pid test done");
  endtask
  task t_monitor;
    freq_cond_pkg::fb_source_t tab[5];
    tab = '{freq_cond_pkg::FB_CURRENT, freq_cond_pkg::FB_VOLTAGE,
      freq_cond_pkg::FB_SERIAL, freq_cond_pkg::FB_PULSE,
      freq_cond_pkg::FB_ARITH};
    ana = '{16'h0064, 16'h00c8, 16'h0, 16'h012c, 16'h0190, 16'h01f4};
    pid.feedback_scale = 14'h00c8;
    for (int i = 0; i < 5; i++) begin
      pid.feedback_source = tab[i];
      settle;
      `CHK(mon, 20'((i + 1) * 200));
    end
    pid.feedback_source = freq_cond_pkg::FB_VOLTAGE;
    pid.feedback_compare_on_level = 10'h032;
    pid.feedback_compare_off_level = 10'h014;
    ana.voltage_input = 16'h0258;
    settle;
    `CHK(cmp_out, 1'b1);
    ana.voltage_input = 16'h012c;
    settle;
    `CHK(cmp_out, 1'b1);
    ana.voltage_input = 16'h0064;
    settle;
    `CHK(cmp_out, 1'b0);
    pid = '0;
    ana = '0;
    $display("monitor test done");
  endtask
  task t_bipolar;
    // zero volts on the bipolar input runs at the lower limit
    cmd = 16'h0;
    lim.upper_limit_set1 = 16'h1388;
    lim.lower_limit_set1 = 16'h03e8;
    bip = 1'b1;
    src = freq_cond_pkg::RUN_SRC_TERMINAL;
    orun = 1'b0;
    fw = 1'b1;
    settle;
    `CHK(out_f, 16'h03e8);
    `CHK(rev, 1'b0);
    fw = 1'b0;
    rv = 1'b1;
    settle;
    `CHK(speed, -17'sh03e8);
    rv = 1'b0;
    src = 2'h0;
    orun = 1'b1;
    odir = freq_cond_pkg::DIR_REVERSE;
    settle;
    `CHK(rev, 1'b1);
    odir = 2'h0;
    settle;
    `CHK(rev, 1'b0);
    bip = 1'b0;
    lim.upper_limit_set1 = 16'h0;
    lim.lower_limit_set1 = 16'h0;
    $display("bipolar test done");
  endtask
  task t_dwell;
    orun = 1'b0;
    dw.accel_dwell_frequency = 16'h03e8;
    dw.accel_dwell_time = 10'h001;
    cmd = 16'h0bb8;
    settle;
    orun = 1'b1;
    settle;
    `CHK(out_f, 16'h03e8);
    `CHK(dwell, 1'b1);
    // one dwell unit is a hundred ticks
    repeat (110 * T) @(negedge clk_sys);
    `CHK(out_f, 16'h0bb8);
    `CHK(dwell, 1'b0);
    $display("dwell test done");
  endtask
  initial begin
    lim.max_frequency_set1 = 16'h2710;
    repeat (20) @(negedge clk_sys);
    sys_rst = 1'b0;
    t_limits;
    t_jump;
    t_pid;
    t_monitor;
    t_bipolar;
    t_dwell;
    conclude;
  end
  // the tests need about 1230 clocks; a hang is cut well after that
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    conclude;
  end
endmodule
